// ===== verilog/mba_pkg.sv
// Constants, register map and types of the multiprocessor bus arbiter node.
// Assumes one common clock for all six nodes sharing the request lines.
// What this block does
// - Own ID drives one line, watches all
// - Six request lines, all at boundary
// - Select pin high rotating, low fixed
// - Rotating: next after master ranks first
// - Transfer only when master drops, others request
// - Master keeps bus while holding request
// - Lone release costs master no cycles
// - Highest priority requester masters next cycle
// - Each node tracks master from lines
// - Changeover costs exactly one cycle
// - Lock keeps bus through read-modify-write
// - Optional cap on master tenure cycles
// - Core priority access beats ongoing DMA
// - Broadcast write reaches all other nodes
// - Master accesses node window directly
// - Eight message registers per node
// - Vector write raises immediate interrupt
package mba_pkg;
   localparam int NUM_NODES = 6;
   localparam int ID_W = 3;
   localparam int DATA_W = 32;
   localparam int ADR_W = 6;
   localparam int TEN_W = 16;
   localparam int NUM_MSG = 8;
   localparam int EXT_REG_W = 4;
   localparam int N_EVT = 5;

   // Register byte offsets on the Wishbone side
   localparam logic [ADR_W-1:0] ADR_CTRL = 6'h00;
   localparam logic [ADR_W-1:0] ADR_STATUS = 6'h04;
   localparam logic [ADR_W-1:0] ADR_MASK = 6'h08;
   localparam logic [ADR_W-1:0] ADR_MASTER = 6'h0c;
   localparam logic [ADR_W-1:0] ADR_VECTOR = 6'h10;
   localparam logic [ADR_W-1:0] ADR_TENURE = 6'h14;
   localparam logic [ADR_W-1:0] ADR_MSG_BASE = 6'h20;

   // Control fields
   localparam int CTRL_LOCK = 0;
   localparam int CTRL_TENURE_EN = 1;
   localparam int CTRL_CPA_EN = 2;
   localparam int CTRL_W = 3;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
   localparam logic [TEN_W-1:0] TENURE_RESET = 16'h0010;

   // Status and mask fields
   localparam int EVT_GAINED = 0;
   localparam int EVT_LOST = 1;
   localparam int EVT_MSG = 2;
   localparam int EVT_VECTOR = 3;
   localparam int EVT_TENURE = 4;

   // Inbound window: register select and broadcast node code
   localparam logic [EXT_REG_W-1:0] EXT_VECTOR = 4'h8;
   localparam logic [ID_W-1:0] EXT_BCAST_NODE = 3'h7;

   typedef enum logic [2:0] {
      ARB_IDLE = 3'b001,
      ARB_HELD = 3'b010,
      ARB_PARKED = 3'b100
   } mba_arb_state_t;
endpackage : mba_pkg

// ===== verilog/mba_node.sv
// One node of the distributed bus arbiter, with its message registers,
// vector interrupt register and Wishbone register port.
// Assumes the six request lines come from logic on the same clock and
// that the priority select and core-priority pins are asynchronous.
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
module mba_node #(
   parameter logic [2:0] NODE_ID = 3'h0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Shared request lines, active low, index i is processor ID i+1
   input wire logic [mba_pkg::NUM_NODES-1:0] bus_request_n_i,
   output logic bus_request_n_o,
   input wire logic priority_scheme_select_i,
   input wire logic core_priority_access_n_i,
   output logic core_priority_access_n_o,
   // Local demand for the external bus
   input wire logic core_req_i,
   input wire logic dma_req_i,
   output logic bus_grant_o,
   output logic [mba_pkg::ID_W-1:0] master_id_o,
   output logic master_valid_o,
   // Inbound accesses from the current bus master
   input wire logic ext_valid_i,
   input wire logic ext_we_i,
   input wire logic [mba_pkg::ID_W-1:0] ext_node_i,
   input wire logic [mba_pkg::EXT_REG_W-1:0] ext_reg_i,
   input wire logic [mba_pkg::DATA_W-1:0] ext_wdata_i,
   output logic ext_ack_o,
   output logic [mba_pkg::DATA_W-1:0] ext_rdata_o,
   // Vector interrupt toward the local core
   output logic vector_irq_o,
   output logic [mba_pkg::DATA_W-1:0] vector_interrupt_address_o,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [mba_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [mba_pkg::DATA_W-1:0] wb_dat_i,
   output logic [mba_pkg::DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o
);
   import mba_pkg::*;

   // Search from base upward with wrap, first requester wins
   function automatic logic [ID_W:0] mba_pick(
      input logic [NUM_NODES-1:0] req,
      input logic [ID_W-1:0] base
   );
      logic [ID_W:0] res;
      logic [ID_W:0] idx;
      res = '0;
      for (int i = NUM_NODES - 1; i >= 0; i--) begin
         idx = {1'b0, base} + (ID_W + 1)'(i);
         if (idx >= (ID_W + 1)'(NUM_NODES)) begin
            idx = idx - (ID_W + 1)'(NUM_NODES);
         end
         if (req[idx[ID_W-1:0]]) begin
            res = {1'b1, idx[ID_W-1:0]};
         end
      end
      return res;
   endfunction : mba_pick

   // Byte-lane merge for Wishbone writes
   function automatic logic [DATA_W-1:0] mba_merge(
      input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] din,
      input logic [3:0] sel
   );
      logic [DATA_W-1:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = din[b*8 +: 8];
         end
      end
      return res;
   endfunction : mba_merge

   logic rps_meta;
   logic rps_sync;
   logic cpa_meta;
   logic cpa_sync;
   logic [NUM_NODES-1:0] req;
   logic [NUM_NODES-1:0] others_req;
   mba_arb_state_t state;
   mba_arb_state_t next_state;
   logic [ID_W-1:0] master_id;
   logic [ID_W-1:0] next_master_id;
   logic [ID_W-1:0] base;
   logic [ID_W:0] pick;
   logic master_drops;
   logic is_master;
   logic [CTRL_W-1:0] ctrl;
   logic [TEN_W-1:0] tenure_limit;
   logic [TEN_W-1:0] hold_cnt;
   logic tenure_drop;
   logic tenure_fire;
   logic cpa_yield;
   logic own_req;
   logic gained;
   logic lost;
   logic [DATA_W-1:0] msg [NUM_MSG];
   logic [DATA_W-1:0] vector_addr;
   logic ext_hit;
   logic ext_wr;
   logic ext_rd_local;
   logic [N_EVT-1:0] status;
   logic [N_EVT-1:0] mask;
   logic [N_EVT-1:0] evt;
   logic wb_fire;
   logic wb_wr;
   logic wb_rd;
   logic [DATA_W-1:0] wb_rdata;

   // Two-flop synchronisers for the asynchronous pins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rps_meta <= 1'b0;
         rps_sync <= 1'b0;
         cpa_meta <= 1'b1;
         cpa_sync <= 1'b1;
      end else begin
         rps_meta <= priority_scheme_select_i;
         rps_sync <= rps_meta;
         cpa_meta <= core_priority_access_n_i;
         cpa_sync <= cpa_meta;
      end
   end

   // Lines are low while asserted; idle positions float high
   assign req = ~bus_request_n_i;
   assign others_req = req & ~(NUM_NODES'(1) << master_id);
   assign master_drops = ~req[master_id];

   // Rotating ranks start just after the master, fixed start at ID1
   assign base = (rps_sync && state != ARB_IDLE) ?
      ((master_id == ID_W'(NUM_NODES - 1)) ? '0 : master_id + 1'b1) :
      '0;
   assign pick = mba_pick(others_req | (state == ARB_IDLE ? req : '0),
      base);

   // Every node runs this same tracker, so all agree on the master
   always_comb begin
      next_state = state;
      next_master_id = master_id;
      case (state)
         ARB_IDLE: begin
            if (pick[ID_W]) begin
               next_state = ARB_HELD;
               next_master_id = pick[ID_W-1:0];
            end
         end
         ARB_HELD: begin
            // Master keeps the bus while its line stays low
            if (master_drops && pick[ID_W]) begin
               next_state = ARB_HELD;
               next_master_id = pick[ID_W-1:0];
            end else if (master_drops) begin
               next_state = ARB_PARKED;
            end
         end
         ARB_PARKED: begin
            // Parked master may resume at once; others force a transfer
            if (!master_drops) begin
               next_state = ARB_HELD;
            end else if (pick[ID_W]) begin
               next_state = ARB_HELD;
               next_master_id = pick[ID_W-1:0];
            end
         end
         default: begin
            next_state = ARB_IDLE;
            next_master_id = '0;
         end
      endcase
   end

   // Master tracking state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ARB_IDLE;
         master_id <= '0;
      end else begin
         state <= next_state;
         master_id <= next_master_id;
      end
   end

   assign is_master = (state != ARB_IDLE) && (master_id == NODE_ID);
   assign gained = (next_state != ARB_IDLE) && (next_master_id == NODE_ID)
      && !is_master;
   assign lost = is_master && (next_master_id != NODE_ID);

   // Cap reached while another node waits; fires once per tenure, and the
   // sum is one bit wider so a saturated count cannot wrap to zero
   assign tenure_fire = is_master && ctrl[CTRL_TENURE_EN] &&
      !ctrl[CTRL_LOCK] && !tenure_drop && |others_req &&
      ({1'b0, hold_cnt} + 17'h1 >= {1'b0, tenure_limit});

   // Tenure counter: cycles held since this node became master
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_cnt <= '0;
         tenure_drop <= 1'b0;
      end else if (!is_master || gained) begin
         hold_cnt <= '0;
         tenure_drop <= 1'b0;
      end else begin
         if (hold_cnt != '1) begin
            hold_cnt <= hold_cnt + 1'b1;
         end
         // Forced release only matters when someone else waits
         if (tenure_fire) begin
            tenure_drop <= 1'b1;
         end
      end
   end

   // A slave core asking with priority pushes a DMA-only master off
   assign cpa_yield = ctrl[CTRL_CPA_EN] && is_master && dma_req_i &&
      !core_req_i && !cpa_sync && !ctrl[CTRL_LOCK];

   // Own request: lock overrides both forced releases
   assign own_req = ctrl[CTRL_LOCK] ? (core_req_i || dma_req_i || is_master)
      : ((core_req_i || dma_req_i) && !tenure_drop && !cpa_yield);

   // Own line and core-priority pin are driven from flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_request_n_o <= 1'b1;
         core_priority_access_n_o <= 1'b1;
      end else begin
         bus_request_n_o <= ~own_req;
         core_priority_access_n_o <= ~(ctrl[CTRL_CPA_EN] && core_req_i &&
            !is_master);
      end
   end

   // Grant while master and our own line is held low
   assign bus_grant_o = is_master && req[NODE_ID];
   assign master_id_o = master_id;
   assign master_valid_o = (state != ARB_IDLE);

   // Inbound window decode: our node or the broadcast window
   assign ext_hit = ext_valid_i && (ext_node_i == NODE_ID ||
      (ext_we_i && ext_node_i == EXT_BCAST_NODE && !is_master));
   assign ext_wr = ext_hit && ext_we_i;
   assign ext_rd_local = ext_hit && !ext_we_i;

   // Inbound read answer, one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_ack_o <= 1'b0;
         ext_rdata_o <= '0;
      end else begin
         ext_ack_o <= ext_hit;
         if (ext_rd_local) begin
            if (ext_reg_i == EXT_VECTOR) begin
               ext_rdata_o <= vector_addr;
            end else if (ext_reg_i < EXT_REG_W'(NUM_MSG)) begin
               ext_rdata_o <= msg[ext_reg_i[2:0]];
            end else begin
               ext_rdata_o <= '0;
            end
         end
      end
   end

   // Wishbone strobes: one request, one ack, ack drops the next cycle
   assign wb_fire = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr = wb_fire && wb_we_i;
   assign wb_rd = wb_fire && !wb_we_i;

   // Message registers: the inbound master wins a same-cycle clash
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_MSG; i++) begin
            msg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_MSG; i++) begin
            if (ext_wr && ext_reg_i == EXT_REG_W'(i)) begin
               msg[i] <= ext_wdata_i;
            end else if (wb_wr &&
                  wb_adr_i == ADR_MSG_BASE + ADR_W'(4 * i)) begin
               msg[i] <= mba_merge(msg[i], wb_dat_i, wb_sel_i);
            end
         end
      end
   end

   // Vector register and its interrupt pulse to the core
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vector_addr <= '0;
         vector_irq_o <= 1'b0;
      end else begin
         vector_irq_o <= ext_wr && ext_reg_i == EXT_VECTOR;
         if (ext_wr && ext_reg_i == EXT_VECTOR) begin
            vector_addr <= ext_wdata_i;
         end
      end
   end
   assign vector_interrupt_address_o = vector_addr;

   // Control, tenure limit and mask registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RESET;
         tenure_limit <= TENURE_RESET;
         mask <= '0;
      end else if (wb_wr) begin
         if (wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
            ctrl <= wb_dat_i[CTRL_W-1:0];
         end
         if (wb_adr_i == ADR_TENURE) begin
            tenure_limit <= TEN_W'(mba_merge({16'h0000, tenure_limit},
               wb_dat_i, wb_sel_i));
         end
         if (wb_adr_i == ADR_MASK && wb_sel_i[0]) begin
            mask <= wb_dat_i[N_EVT-1:0];
         end
      end
   end

   // Sticky events; a read of status clears, a new event wins the clash
   always_comb begin
      evt = '0;
      evt[EVT_GAINED] = gained;
      evt[EVT_LOST] = lost;
      evt[EVT_MSG] = ext_wr && ext_reg_i < EXT_REG_W'(NUM_MSG);
      evt[EVT_VECTOR] = ext_wr && ext_reg_i == EXT_VECTOR;
      evt[EVT_TENURE] = tenure_fire;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status <= '0;
      end else if (wb_rd && wb_adr_i == ADR_STATUS) begin
         status <= evt;
      end else begin
         status <= status | evt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(next_status_q(status, evt, wb_rd) & mask);
      end
   end

   // Status value that the register will hold after this edge
   function automatic logic [N_EVT-1:0] next_status_q(
      input logic [N_EVT-1:0] cur,
      input logic [N_EVT-1:0] ev,
      input logic rd
   );
      logic [N_EVT-1:0] res;
      res = (rd && wb_adr_i == ADR_STATUS) ? ev : (cur | ev);
      return res;
   endfunction : next_status_q

   // Read mux; unmapped addresses read zero
   always_comb begin
      wb_rdata = '0;
      case (wb_adr_i)
         ADR_CTRL: wb_rdata[CTRL_W-1:0] = ctrl;
         ADR_STATUS: wb_rdata[N_EVT-1:0] = status;
         ADR_MASK: wb_rdata[N_EVT-1:0] = mask;
         ADR_MASTER: wb_rdata[ID_W+1:0] = {rps_sync, master_valid_o,
            master_id};
         ADR_VECTOR: wb_rdata = vector_addr;
         ADR_TENURE: wb_rdata[TEN_W-1:0] = tenure_limit;
         default: begin
            if (wb_adr_i >= ADR_MSG_BASE) begin
               wb_rdata = msg[wb_adr_i[4:2]];
            end
         end
      endcase
   end

   // Ack and read data one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_fire;
         if (wb_rd) begin
            wb_dat_o <= wb_rdata;
         end
      end
   end
endmodule : mba_node

// ===== verif/mba_checker.sv
// Port checks for one arbiter node.
// Assumes the own line is wired back into bus_request_n_i.
`timescale 1ns/10ps
module mba_checker
   import mba_pkg::*;
#(
   parameter logic [2:0] NODE_ID = 3'h0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [mba_pkg::NUM_NODES-1:0] bus_request_n_i,
   input wire logic bus_request_n_o,
   input wire logic priority_scheme_select_i,
   input wire logic core_req_i,
   input wire logic dma_req_i,
   input wire logic bus_grant_o,
   input wire logic [mba_pkg::ID_W-1:0] master_id_o,
   input wire logic master_valid_o,
   input wire logic ext_valid_i,
   input wire logic ext_we_i,
   input wire logic [mba_pkg::ID_W-1:0] ext_node_i,
   input wire logic [mba_pkg::EXT_REG_W-1:0] ext_reg_i,
   input wire logic [mba_pkg::DATA_W-1:0] ext_wdata_i,
   input wire logic ext_ack_o,
   input wire logic vector_irq_o,
   input wire logic [mba_pkg::DATA_W-1:0] vector_interrupt_address_o
);
   logic [2:0] fix_w;
   logic [2:0] rot_w;
   logic any_req;
   logic mst_off;

   function automatic logic [2:0] first_req(input logic [5:0] rn,
                                           input logic [2:0] b);
      logic [2:0] r;
      int i;
      r = b;
      for (int k = 5; k >= 0; k--) begin
         i = (int'(b) + k) % 6;
         if (!rn[i]) r = 3'(i);
      end
      return r;
   endfunction : first_req

   // Expected winners; rotating order puts the master last
   always_comb begin
      fix_w = first_req(bus_request_n_i, 3'h0);
      rot_w = first_req(bus_request_n_i,
         (master_id_o == 3'h5) ? 3'h0 : master_id_o + 3'h1);
      any_req = !(&bus_request_n_i);
      mst_off = master_valid_o && bus_request_n_i[master_id_o];
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   own_line_a: assert property (
      $rose(core_req_i) && !dma_req_i |=> !bus_request_n_o)
      else $error("own request line not driven");
   grant_view_a: assert property (
      bus_grant_o |-> !bus_request_n_o && master_valid_o &&
      master_id_o == NODE_ID) else $error("grant without mastership");
   master_hold_a: assert property (
      master_valid_o && !bus_request_n_i[master_id_o] |=>
      master_valid_o && $stable(master_id_o)) else $error("master lost");
   one_cycle_change_a: assert property (
      mst_off && any_req |=> master_id_o != $past(master_id_o))
      else $error("changeover late");
   parked_master_a: assert property (
      mst_off && !any_req |=> master_valid_o && $stable(master_id_o))
      else $error("parked master moved");
   fixed_winner_a: assert property (
      !priority_scheme_select_i [*4] ##0 ((mst_off || !master_valid_o)
      && any_req) |=> master_id_o == $past(fix_w))
      else $error("fixed winner wrong");
   rotating_winner_a: assert property (
      priority_scheme_select_i [*4] ##0 (mst_off && any_req) |=>
      master_id_o == $past(rot_w)) else $error("rotating winner wrong");
   window_ack_a: assert property (
      ext_valid_i && ext_node_i == NODE_ID |=> ext_ack_o)
      else $error("inbound access not answered");
   idle_ack_a: assert property (
      !ext_valid_i |=> !ext_ack_o) else $error("ack without access");
   vector_irq_a: assert property (
      ext_valid_i && ext_we_i && ext_node_i == NODE_ID &&
      ext_reg_i == EXT_VECTOR |=> vector_irq_o &&
      vector_interrupt_address_o == $past(ext_wdata_i))
      else $error("vector write without interrupt");

   cover property (mst_off && any_req);
   cover property (mst_off && !any_req);
   cover property (vector_irq_o);
endmodule : mba_checker

bind mba_node mba_checker #(.NODE_ID(NODE_ID)) i_chk (.clk_i, .rst_i,
   .bus_request_n_i, .bus_request_n_o, .priority_scheme_select_i,
   .core_req_i, .dma_req_i, .bus_grant_o, .master_id_o, .master_valid_o,
   .ext_valid_i, .ext_we_i, .ext_node_i, .ext_reg_i, .ext_wdata_i,
   .ext_ack_o, .vector_irq_o, .vector_interrupt_address_o);

// ===== verif/mba_peers.sv
// Peer nodes on the shared request lines and the core-priority line.
// Assumes the bench says which peers want the bus; index 0 is the DUT.
`timescale 1ns/10ps
module mba_peers
   import mba_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [mba_pkg::NUM_NODES-1:1] want_i,
   input wire logic cpa_i,
   output logic [mba_pkg::NUM_NODES-1:1] req_n_o,
   output logic cpa_n_o
);
   // Each peer drives only its own line, low while it wants the bus
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_n_o <= 5'h1f;
         cpa_n_o <= 1'b1;
      end else begin
         req_n_o <= ~want_i;
         cpa_n_o <= ~cpa_i;
      end
   end
endmodule : mba_peers

// ===== verif/tb_top.sv
// Bench for one arbiter node facing five modelled peers.
// Assumes Wishbone answers within a few cycles.
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
   n_mismatch++; $display("mismatch %0t: %h vs %h", $time, g, e); end end
module tb_top;
   import mba_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [NUM_NODES-1:0] bus_request_n_i;
   logic bus_request_n_o;
   logic priority_scheme_select_i = 1'b0;
   logic core_priority_access_n_i;
   logic core_priority_access_n_o;
   logic core_req_i = 1'b0;
   logic dma_req_i = 1'b0;
   logic bus_grant_o;
   logic [ID_W-1:0] master_id_o;
   logic master_valid_o;
   logic ext_valid_i = 1'b0;
   logic ext_we_i = 1'b0;
   logic [ID_W-1:0] ext_node_i = 3'h0;
   logic [EXT_REG_W-1:0] ext_reg_i = 4'h0;
   logic [DATA_W-1:0] ext_wdata_i = 32'h0;
   logic ext_ack_o;
   logic [DATA_W-1:0] ext_rdata_o;
   logic vector_irq_o;
   logic [DATA_W-1:0] vector_interrupt_address_o;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [ADR_W-1:0] wb_adr_i = 6'h0;
   logic [3:0] wb_sel_i = 4'hf;
   logic [DATA_W-1:0] wb_dat_i = 32'h0;
   logic [DATA_W-1:0] wb_dat_o;
   logic wb_ack_o;
   logic irq_o;
   logic [NUM_NODES-1:1] want = 5'h00;
   logic [NUM_NODES-1:1] peer_n;
   logic core_priority_access = 1'b0;
   logic cpa_n;
   logic [31:0] q;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;

   // Wired lines: own line fed back, core-priority line wired-AND
   assign bus_request_n_i = {peer_n, bus_request_n_o};
   assign core_priority_access_n_i = cpa_n & core_priority_access_n_o;
   always #20 clk_i = ~clk_i;

   mba_node #(.NODE_ID(3'h0)) i_dut (.clk_i, .rst_i, .bus_request_n_i,
      .bus_request_n_o, .priority_scheme_select_i,
      .core_priority_access_n_i, .core_priority_access_n_o, .core_req_i,
      .dma_req_i, .bus_grant_o, .master_id_o, .master_valid_o,
      .ext_valid_i, .ext_we_i, .ext_node_i, .ext_reg_i, .ext_wdata_i,
      .ext_ack_o, .ext_rdata_o, .vector_irq_o, .vector_interrupt_address_o,
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .irq_o);
   mba_peers i_peers (.clk_i, .rst_i, .want_i(want), .cpa_i(core_priority_access),
      .req_n_o(peer_n), .cpa_n_o(cpa_n));

   task automatic give_verdict();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict

   // Classic cycle: hold everything until ack is seen at an edge
   task automatic wb(input logic we, input logic [5:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin @(posedge clk_i); n++; end
      while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      if (n >= 20) n_mismatch++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb

   task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask : rd_chk

   // One-cycle inbound pulse; ack is looked at one cycle later
   task automatic ext(input logic we, input logic [2:0] nd,
                      input logic [3:0] r, input logic [31:0] d,
                      input logic ea);
      @(posedge clk_i);
      ext_valid_i <= 1'b1;
      ext_we_i <= we;
      ext_node_i <= nd;
      ext_reg_i <= r;
      ext_wdata_i <= d;
      @(posedge clk_i);
      ext_valid_i <= 1'b0;
      @(posedge clk_i);
      `CHK(ext_ack_o, ea)
      q = ext_rdata_o;
   endtask : ext

   task automatic wait_mst(input logic [2:0] id);
      int n;
      n = 0;
      while ((master_valid_o !== 1'b1 || master_id_o !== id) && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      `CHK(master_valid_o, 1'b1)
      `CHK(master_id_o, id)
   endtask : wait_mst

   // Hang guard, far above the fewer than two hundred cycles the run needs
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(ADR_CTRL, 32'h0);
      rd_chk(ADR_TENURE, 32'h10);
      rd_chk(ADR_MASTER, 32'h0);
      rd_chk(6'h1c, 32'h0);
      ext(1'b1, 3'h0, 4'h3, 32'h1234_5678, 1'b1);
      rd_chk(ADR_MSG_BASE + 6'hc, 32'h1234_5678);
      ext(1'b0, 3'h0, 4'h3, 32'h0, 1'b1);
      `CHK(q, 32'h1234_5678)
      ext(1'b1, 3'h4, 4'h3, 32'h0, 1'b0);
      ext(1'b1, EXT_BCAST_NODE, 4'h5, 32'h00ab_cdef, 1'b1);
      rd_chk(ADR_MSG_BASE + 6'h14, 32'h00ab_cdef);
      ext(1'b0, EXT_BCAST_NODE, 4'h5, 32'h0, 1'b0);
      ext(1'b1, 3'h0, EXT_VECTOR, 32'h0000_0400, 1'b1);
      rd_chk(ADR_VECTOR, 32'h400);
      `CHK(vector_interrupt_address_o, 32'h400)
      `CHK(irq_o, 1'b0)
      wb(1'b1, ADR_MASK, 32'h1f);
      @(posedge clk_i);
      `CHK(irq_o, 1'b1)
      rd_chk(ADR_STATUS, 32'hc);
      @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      // Fixed order, then a held master, then a parked one
      want <= 5'h06;
      wait_mst(3'h2);
      core_req_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      `CHK(master_id_o, 3'h2)
      want <= 5'h04;
      wait_mst(3'h0);
      `CHK(bus_grant_o, 1'b1)
      want <= 5'h00;
      repeat (2) @(posedge clk_i);
      core_req_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      `CHK(master_id_o, 3'h0)
      rd_chk(ADR_STATUS, 32'h1);
      // Rotating order: a fresh master ranks last
      priority_scheme_select_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      want <= 5'h11;
      wait_mst(3'h1);
      core_req_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      want <= 5'h10;
      wait_mst(3'h5);
      rd_chk(ADR_MASTER, 32'h1d);
      want <= 5'h00;
      wait_mst(3'h0);
      rd_chk(ADR_STATUS, 32'h3);
      // Locked master keeps the bus with no demand left
      wb(1'b1, ADR_CTRL, 32'h1);
      core_req_i <= 1'b0;
      want <= 5'h02;
      repeat (8) @(posedge clk_i);
      `CHK(bus_request_n_o, 1'b0)
      `CHK(master_id_o, 3'h0)
      wb(1'b1, ADR_CTRL, 32'h0);
      wait_mst(3'h2);
      // A slave core request beats the master's DMA
      wb(1'b1, ADR_CTRL, 32'h4);
      dma_req_i <= 1'b1;
      want <= 5'h00;
      wait_mst(3'h0);
      want <= 5'h04;
      core_priority_access <= 1'b1;
      wait_mst(3'h3);
      core_req_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK(core_priority_access_n_o, 1'b0)
      // Tenure cap forces a long DMA master to give way
      core_req_i <= 1'b0;
      core_priority_access <= 1'b0;
      // Only lane 0 enabled: the upper lane of the limit must stay zero
      wb_sel_i <= 4'h1;
      wb(1'b1, ADR_TENURE, 32'h0000_ff04);
      wb_sel_i <= 4'hf;
      rd_chk(ADR_TENURE, 32'h4);
      wb(1'b1, ADR_CTRL, 32'h2);
      want <= 5'h00;
      wait_mst(3'h0);
      want <= 5'h08;
      wait_mst(3'h4);
      give_verdict();
   end
endmodule : tb_top
